// [pkg/wch_regs.svh]
// Constants for waveform capture and harmonic analysis
`ifndef WCH_REGS_SVH
`define WCH_REGS_SVH
`define WCH_CLK_HZ 100000000
`define WCH_SAMPLE_BITS 12
`define WCH_CHAN_COUNT 10
`define WCH_DISP_DEPTH 100
`define WCH_DISP_RATE_SPS 2048
`define WCH_ANL_DEPTH 1024
`define WCH_ANL_RATE_SPS 8196
`define WCH_ANL_PERIOD_MS 500
`define WCH_HARM_MAX_ORDER 49
`define WCH_HARM_MAX_HZ 2500
`define WCH_PHASE_BITS 16
`define WCH_LEVEL_FULL 1000
`define WCH_LEVEL_BITS 10
`define WCH_THD_BITS 13
`define WCH_GAIN_KNEE_0 1024
`define WCH_GAIN_KNEE_1 512
`define WCH_GAIN_KNEE_2 256
`endif

// [pkg/wch_pkg.sv]
// Types for waveform capture and harmonic analysis
package wch_pkg;
  // Source channels offered by the front end
  typedef enum logic [3:0] {
    CH_V1, CH_V2, CH_V3, CH_U12, CH_U23, CH_U31, CH_I1, CH_I2, CH_I3, CH_IN
  } wch_chan_type;
  // Analysis sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_BIN, ST_DIV, ST_ROOT, ST_FIN} wch_state_type;
endpackage

// [design/wch_dft_bin.sv]
// Single-bin correlator: one harmonic over a frozen sample block
`timescale 1ns/1ps
`include "wch_regs.svh"
module wch_dft_bin (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic clear_in, // Restart accumulation
  input wire logic valid_in, // Sample present this cycle
  input wire logic signed [11:0] sample_in, // Sample, two's complement
  input wire logic [15:0] step_in, // Phase step per sample
  output logic [35:0] mag_out // Approximate magnitude |re|+|im|
);
  logic [15:0] phase_reg;
  logic signed [35:0] re_reg;
  logic signed [35:0] im_reg;

  ////////////////////////////////////////////////////////////////
  // Quarter-wave sine table, full scale 2047
  function automatic logic [11:0] quarter(input logic [4:0] i);
    case (i)
      5'h00: quarter = 12'h000;
      5'h01: quarter = 12'h0c9;
      5'h02: quarter = 12'h18f;
      5'h03: quarter = 12'h252;
      5'h04: quarter = 12'h30f;
      5'h05: quarter = 12'h3c5;
      5'h06: quarter = 12'h471;
      5'h07: quarter = 12'h513;
      5'h08: quarter = 12'h5a7;
      5'h09: quarter = 12'h62e;
      5'h0a: quarter = 12'h6a6;
      5'h0b: quarter = 12'h70d;
      5'h0c: quarter = 12'h763;
      5'h0d: quarter = 12'h7a7;
      5'h0e: quarter = 12'h7d8;
      5'h0f: quarter = 12'h7f5;
      default: quarter = 12'h7ff;
    endcase
  endfunction

  // Full sine from 64-step phase
  function automatic logic signed [12:0] wave(input logic [5:0] p);
    logic [11:0] a;
    a = p[4] ? quarter(5'h10 - {1'b0, p[3:0]}) : quarter({1'b0, p[3:0]});
    wave = p[5] ? -$signed({1'b0, a}) : $signed({1'b0, a});
  endfunction

  ////////////////////////////////////////////////////////////////
  // Products against sine and cosine of the running phase
  wire signed [12:0] sin_w = wave(phase_reg[15:10]);
  wire signed [12:0] cos_w = wave(phase_reg[15:10] + 6'h10);
  wire signed [24:0] re_prod = sample_in * cos_w;
  wire signed [24:0] im_prod = sample_in * sin_w;
  wire [35:0] re_abs = re_reg[35] ? 36'(-re_reg) : 36'(re_reg);
  wire [35:0] im_abs = im_reg[35] ? 36'(-im_reg) : 36'(im_reg);

  // Accumulate correlation over the block
  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      phase_reg <= 16'h0000;
      re_reg <= 36'sh0;
      im_reg <= 36'sh0;
    end else if (valid_in) begin
      phase_reg <= phase_reg + step_in;
      re_reg <= re_reg + 36'(re_prod);
      im_reg <= im_reg + 36'(im_prod);
    end
  end

  assign mag_out = 36'(re_abs + im_abs);
endmodule // wch_dft_bin

// [design/wch_capture_top.sv]
// Waveform display capture and periodic harmonic analysis
`timescale 1ns/1ps
`include "wch_regs.svh"
// Notes on behaviour
// - Display buffer keeps 100 twelve-bit samples at 2048 samples per second.
// - Display gain follows the peak of the last completed sweep, chosen so that sweep does not clip.
// - Display buffer contents are readable through an external read port.
// - Harmonic analysis of the selected channel runs twice per second.
// - Each analysis uses its own 1024-sample, 12-bit buffer at 8196 samples/s.
// - Harmonic orders stop at the lower of 2500 Hz or order 49.
// - Source may be any phase-neutral, phase-phase voltage or current input.
// - Total harmonic distortion is reported in 0.1 percent steps.
// - Each harmonic level is reported in 0.1 percent steps.
module wch_capture_top #(
  parameter int DISP_DIV = `WCH_CLK_HZ / `WCH_DISP_RATE_SPS, // Cycles per display sample
  parameter int ANL_DIV = `WCH_CLK_HZ / `WCH_ANL_RATE_SPS, // Cycles per analysis sample
  parameter int ANL_PERIOD = (`WCH_CLK_HZ / 1000) * `WCH_ANL_PERIOD_MS // Cycles between analyses
) (
  input wire logic CLK_IN, // System clock
  input wire logic SYS_RST_IN, // Synchronous reset, active high
  input wire wch_pkg::wch_chan_type CHAN_SEL_IN, // Selected source channel
  input wire logic [`WCH_CHAN_COUNT*12-1:0] SAMPLES_IN, // All channel samples, channel 0 low
  input wire logic [15:0] FUND_STEP_IN, // Fundamental phase step per analysis sample
  input wire logic [6:0] DISP_RD_ADDR_IN, // Display buffer read index
  input wire logic [5:0] HARM_RD_ORDER_IN, // Harmonic order to read
  output logic [11:0] DISP_RD_DATA_OUT, // Display sample read data
  output logic [6:0] DISP_WR_PTR_OUT, // Oldest display sample index
  output logic [1:0] DISP_GAIN_OUT, // Display left shift without clipping
  output logic [9:0] HARM_LEVEL_OUT, // Harmonic level in 0.1 percent
  output logic [12:0] THD_OUT, // Total distortion in 0.1 percent
  output logic [5:0] HARM_MAX_OUT, // Highest order computed
  output logic RESULT_VALID_OUT, // Results hold at least one analysis
  output logic RESULT_UPDATE_OUT, // One-cycle pulse on result swap
  output logic BUSY_OUT // Analysis in progress
);
  import wch_pkg::*;

  localparam int DISP_N = `WCH_DISP_DEPTH;
  localparam int ANL_N = `WCH_ANL_DEPTH;
  localparam logic [16:0] STEP_LIMIT = 17'((`WCH_HARM_MAX_HZ * 65536) / `WCH_ANL_RATE_SPS);
  localparam logic [5:0] ORDER_MAX = 6'(`WCH_HARM_MAX_ORDER);
  localparam logic [9:0] LEVEL_FULL = 10'(`WCH_LEVEL_FULL);

  ////////////////////////////////////////////////////////////////
  // Storage
  logic [11:0] disp_mem [0:DISP_N-1];
  logic [11:0] anl_mem [0:ANL_N-1];
  logic [9:0] res_mem [0:127];

  logic [31:0] disp_div_reg;
  logic [31:0] anl_div_reg;
  logic [31:0] period_reg;
  logic [6:0] disp_ptr_reg;
  logic [10:0] peak_reg;
  logic [10:0] anl_cnt_reg;
  wch_state_type state_reg;
  wch_state_type state_next;
  logic [10:0] rd_cnt_reg;
  logic rd_valid_reg;
  logic [11:0] rd_data_reg;
  logic [5:0] order_reg;
  logic [16:0] hstep_reg;
  logic [35:0] mag1_reg;
  logic [47:0] rem_reg;
  logic [9:0] quot_reg;
  logic [3:0] bit_reg;
  logic [25:0] sum_reg;
  logic [12:0] root_reg;
  logic bank_reg;
  logic [35:0] mag_w;

  ////////////////////////////////////////////////////////////////
  // Rate enables and channel selection
  wire disp_tick = (disp_div_reg == 32'(DISP_DIV - 1));
  wire anl_tick = (anl_div_reg == 32'(ANL_DIV - 1));
  wire period_tick = (period_reg == 32'(ANL_PERIOD - 1));
  wire [11:0] sel_sample = SAMPLES_IN[CHAN_SEL_IN*12 +: 12];
  wire [10:0] sel_abs = (sel_sample == 12'h800) ? 11'h7ff : sel_sample[11] ? 11'(-sel_sample) : sel_sample[10:0];
  wire anl_full = (anl_cnt_reg == 11'(ANL_N));
  wire anl_write = anl_tick && !anl_full && (state_reg == ST_IDLE);
  wire disp_wrap = (disp_ptr_reg == 7'(DISP_N - 1));

  // Dividers for the two sample rates and the analysis period
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      disp_div_reg <= 32'h0;
      anl_div_reg <= 32'h0;
      period_reg <= 32'h0;
    end else begin
      disp_div_reg <= disp_tick ? 32'h0 : disp_div_reg + 32'h1;
      anl_div_reg <= anl_tick ? 32'h0 : anl_div_reg + 32'h1;
      period_reg <= period_tick ? 32'h0 : period_reg + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Largest gain that keeps the sweep peak inside full scale
  wire [10:0] peak_all = (sel_abs > peak_reg) ? sel_abs : peak_reg;
  wire [1:0] gain_w = (peak_all < 11'(`WCH_GAIN_KNEE_2)) ? 2'h3 :
                      (peak_all < 11'(`WCH_GAIN_KNEE_1)) ? 2'h2 :
                      (peak_all < 11'(`WCH_GAIN_KNEE_0)) ? 2'h1 : 2'h0;

  // Display ring buffer and peak tracking per sweep
  always_ff @(posedge CLK_IN) begin
    if (disp_tick) begin
      disp_mem[disp_ptr_reg] <= sel_sample;
    end
    DISP_RD_DATA_OUT <= (DISP_RD_ADDR_IN < 7'(DISP_N)) ? disp_mem[DISP_RD_ADDR_IN] : 12'h000;
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      disp_ptr_reg <= 7'h00;
      peak_reg <= 11'h000;
      DISP_GAIN_OUT <= 2'h0;
    end else if (disp_tick) begin
      disp_ptr_reg <= disp_wrap ? 7'h00 : disp_ptr_reg + 7'h01;
      peak_reg <= disp_wrap ? 11'h000 : ((sel_abs > peak_reg) ? sel_abs : peak_reg);
      if (disp_wrap) begin
        DISP_GAIN_OUT <= gain_w;
      end
    end
  end

  // Oldest sample index, one cycle behind the pointer
  always_ff @(posedge CLK_IN) begin
    DISP_WR_PTR_OUT <= SYS_RST_IN ? 7'h00 : disp_ptr_reg;
  end

  ////////////////////////////////////////////////////////////////
  // Analysis buffer fill, frozen while the sequencer runs
  always_ff @(posedge CLK_IN) begin
    if (anl_write) begin
      anl_mem[anl_cnt_reg[9:0]] <= sel_sample;
    end
    rd_data_reg <= anl_mem[rd_cnt_reg[9:0]];
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || state_reg == ST_FIN) begin
      anl_cnt_reg <= 11'h000;
    end else if (anl_write) begin
      anl_cnt_reg <= anl_cnt_reg + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer decode
  wire start_anl = (state_reg == ST_IDLE) && period_tick && anl_full;
  wire issue = (state_reg == ST_BIN) && (rd_cnt_reg != 11'(ANL_N));
  wire bin_done = (state_reg == ST_BIN) && !issue && !rd_valid_reg;
  wire [16:0] hstep_nx = hstep_reg + {1'b0, FUND_STEP_IN};
  wire more = (order_reg < ORDER_MAX) && (hstep_nx <= STEP_LIMIT);
  wire [47:0] div_den = 48'(mag1_reg) << bit_reg;
  wire [47:0] div_sat = 48'(mag1_reg) << 10;
  wire [47:0] scaled = 48'(mag_w) * 48'(`WCH_LEVEL_FULL);
  wire div_hit = rem_reg >= div_den;
  wire [12:0] root_try = root_reg | (13'h1 << bit_reg);
  wire [25:0] root_sq = 26'(root_try) * 26'(root_try);
  wire to_bin = start_anl || (state_next == ST_BIN && state_reg != ST_BIN) || (bin_done && order_reg == 6'h01 && more);
  // Quotient including the bit decided this cycle, so the last bit is not lost
  wire [9:0] quot_step = (div_hit && quot_reg != 10'h3ff) ? (quot_reg | (10'h001 << bit_reg)) : quot_reg;
  wire [9:0] div_level = (mag1_reg == 36'h0) ? 10'h000 : quot_step;

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (start_anl) state_next = ST_BIN;
      ST_BIN: begin
        if (bin_done) begin
          if (order_reg != 6'h01) state_next = ST_DIV;
          else if (!more) state_next = ST_ROOT;
        end
      end
      ST_DIV: if (bit_reg == 4'h0) state_next = more ? ST_BIN : ST_ROOT;
      ST_ROOT: if (bit_reg == 4'h0) state_next = ST_FIN;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    state_reg <= SYS_RST_IN ? ST_IDLE : state_next;
  end

  // Sample read stream into the correlator
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || to_bin) begin
      rd_cnt_reg <= 11'h000;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_cnt_reg <= issue ? rd_cnt_reg + 11'h001 : rd_cnt_reg;
      rd_valid_reg <= issue;
    end
  end

  wch_dft_bin u_bin (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .clear_in(to_bin),
    .valid_in(rd_valid_reg),
    .sample_in(rd_data_reg),
    .step_in(hstep_reg[15:0]),
    .mag_out(mag_w)
  );

  ////////////////////////////////////////////////////////////////
  // Harmonic order stepping, division to 0.1 percent, root of sum
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || start_anl) begin
      order_reg <= 6'h01;
      hstep_reg <= {1'b0, FUND_STEP_IN};
      sum_reg <= 26'h0;
    end else if ((bin_done && order_reg == 6'h01 && more) || (state_reg == ST_DIV && bit_reg == 4'h0 && more)) begin
      order_reg <= order_reg + 6'h01;
      hstep_reg <= hstep_nx;
    end
    if (!SYS_RST_IN && !start_anl && state_reg == ST_DIV && bit_reg == 4'h0) begin
      sum_reg <= sum_reg + 26'(div_level) * 26'(div_level);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      mag1_reg <= 36'h0;
      rem_reg <= 48'h0;
      quot_reg <= 10'h000;
      bit_reg <= 4'h0;
      root_reg <= 13'h0000;
    end else if (bin_done && order_reg == 6'h01) begin
      mag1_reg <= mag_w;
      bit_reg <= 4'hc;
      root_reg <= 13'h0000;
    end else if (bin_done) begin
      rem_reg <= scaled;
      quot_reg <= (scaled >= div_sat) ? 10'h3ff : 10'h000;
      bit_reg <= (scaled >= div_sat) ? 4'h0 : 4'h9;
    end else if (state_reg == ST_DIV) begin
      if (div_hit && quot_reg != 10'h3ff) begin
        rem_reg <= rem_reg - div_den;
        quot_reg <= quot_reg | (10'h001 << bit_reg);
      end
      bit_reg <= (bit_reg == 4'h0) ? 4'hc : bit_reg - 4'h1;
    end else if (state_reg == ST_ROOT) begin
      root_reg <= (root_sq <= sum_reg) ? root_try : root_reg;
      bit_reg <= bit_reg - 4'h1;
    end
  end

  // Results land in the hidden bank; the visible bank stays intact
  always_ff @(posedge CLK_IN) begin
    if (bin_done && order_reg == 6'h01) begin
      res_mem[{~bank_reg, order_reg}] <= LEVEL_FULL;
    end else if (state_reg == ST_DIV && bit_reg == 4'h0) begin
      res_mem[{~bank_reg, order_reg}] <= div_level;
    end
    HARM_LEVEL_OUT <= (HARM_RD_ORDER_IN == 6'h00 || HARM_RD_ORDER_IN > HARM_MAX_OUT) ? 10'h000 :
                      res_mem[{bank_reg, HARM_RD_ORDER_IN}];
  end

  ////////////////////////////////////////////////////////////////
  // Swap banks and publish once the whole analysis has finished
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      bank_reg <= 1'b0;
      THD_OUT <= 13'h0000;
      HARM_MAX_OUT <= 6'h00;
      RESULT_VALID_OUT <= 1'b0;
      RESULT_UPDATE_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
    end else begin
      RESULT_UPDATE_OUT <= (state_reg == ST_FIN);
      BUSY_OUT <= (state_next != ST_IDLE);
      if (state_reg == ST_FIN) begin
        bank_reg <= ~bank_reg;
        THD_OUT <= root_reg;
        HARM_MAX_OUT <= order_reg;
        RESULT_VALID_OUT <= 1'b1;
      end
    end
  end
endmodule // wch_capture_top

// [testbench/wch_capture_properties.sv]
// Checker for display capture and analysis result timing
`timescale 1ns/1ps
module wch_capture_properties #(
  parameter int DISP_DIV = 4 // Cycles per display sample
) (
  input wire logic CLK_IN, // Clock
  input wire logic SYS_RST_IN, // Reset
  input wire logic [15:0] FUND_STEP_IN, // Phase step
  input wire logic [6:0] DISP_RD_ADDR_IN, // Read index
  input wire logic [5:0] HARM_RD_ORDER_IN, // Order read
  input wire logic [11:0] DISP_RD_DATA_OUT, // Read data
  input wire logic [6:0] DISP_WR_PTR_OUT, // Write index
  input wire logic [1:0] DISP_GAIN_OUT, // Gain
  input wire logic [9:0] HARM_LEVEL_OUT, // Level
  input wire logic [12:0] THD_OUT, // Distortion
  input wire logic [5:0] HARM_MAX_OUT, // Top order
  input wire logic RESULT_VALID_OUT, // Valid
  input wire logic RESULT_UPDATE_OUT, // Swap pulse
  input wire logic BUSY_OUT // Busy
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  ////////////////////////////////////////////////////////////
  // Pointer history and cycles since the pointer last moved
  logic [6:0] ptr_last_reg;
  logic [31:0] gap_reg;
  logic seen_reg;
  wire logic ptr_moved = DISP_WR_PTR_OUT != ptr_last_reg;
  always_ff @(posedge CLK_IN) begin
    ptr_last_reg <= DISP_WR_PTR_OUT;
    gap_reg <= (SYS_RST_IN || ptr_moved) ? 32'h0 : gap_reg + 32'h1;
    seen_reg <= !SYS_RST_IN && (seen_reg || ptr_moved);
  end
  ////////////////////////////////////////////////////////////
  // A result swap lasts a single cycle
  sequence s_swap;
    RESULT_UPDATE_OUT ##1 !RESULT_UPDATE_OUT;
  endsequence
  // Display capture
  a_ptr_in_range: assert property (DISP_WR_PTR_OUT <= 7'h63)
    else $error("display pointer beyond last slot");
  a_ptr_wraps: assert property (ptr_moved |->
    DISP_WR_PTR_OUT == ((ptr_last_reg == 7'h63) ? 7'h00 : ptr_last_reg + 7'h01))
    else $error("display pointer skipped a slot");
  a_ptr_rate: assert property (ptr_moved && seen_reg |-> gap_reg == 32'(DISP_DIV - 1))
    else $error("display sample spacing wrong");
  a_gain_at_sweep: assert property ($changed(DISP_GAIN_OUT) |-> DISP_WR_PTR_OUT inside {7'h63, 7'h00, 7'h01})
    else $error("display gain changed mid sweep");
  a_read_refused: assert property (DISP_RD_ADDR_IN >= 7'h64 |=> DISP_RD_DATA_OUT == 12'h000)
    else $error("display read beyond buffer not zero");
  // Analysis results
  a_swap_pulse: assert property (RESULT_UPDATE_OUT |-> s_swap)
    else $error("result swap longer than one cycle");
  a_swap_after_busy: assert property (RESULT_UPDATE_OUT |-> BUSY_OUT || $past(BUSY_OUT))
    else $error("result swap without analysis");
  a_results_hold: assert property (!RESULT_UPDATE_OUT && !$past(RESULT_UPDATE_OUT) |->
    $stable(THD_OUT) && $stable(HARM_MAX_OUT))
    else $error("results moved between swaps");
  a_valid_with_swap: assert property ($rose(RESULT_VALID_OUT) |-> RESULT_UPDATE_OUT)
    else $error("results valid without swap");
  a_order_limit: assert property (RESULT_UPDATE_OUT |=> HARM_MAX_OUT <= 6'h31 &&
    32'(HARM_MAX_OUT) * 32'(FUND_STEP_IN) <= 32'h4e16 &&
    (HARM_MAX_OUT == 6'h31 || 32'(HARM_MAX_OUT + 6'h01) * 32'(FUND_STEP_IN) > 32'h4e16))
    else $error("top harmonic order wrong");
  a_order_zero: assert property (HARM_RD_ORDER_IN == 6'h00 && RESULT_VALID_OUT |=> HARM_LEVEL_OUT == 10'h000)
    else $error("order zero level not zero");
endmodule // wch_capture_properties
bind wch_capture_top wch_capture_properties #(.DISP_DIV(DISP_DIV)) u_props (
  .CLK_IN(CLK_IN),
  .SYS_RST_IN(SYS_RST_IN),
  .FUND_STEP_IN(FUND_STEP_IN),
  .DISP_RD_ADDR_IN(DISP_RD_ADDR_IN),
  .HARM_RD_ORDER_IN(HARM_RD_ORDER_IN),
  .DISP_RD_DATA_OUT(DISP_RD_DATA_OUT),
  .DISP_WR_PTR_OUT(DISP_WR_PTR_OUT),
  .DISP_GAIN_OUT(DISP_GAIN_OUT),
  .HARM_LEVEL_OUT(HARM_LEVEL_OUT),
  .THD_OUT(THD_OUT),
  .HARM_MAX_OUT(HARM_MAX_OUT),
  .RESULT_VALID_OUT(RESULT_VALID_OUT),
  .RESULT_UPDATE_OUT(RESULT_UPDATE_OUT),
  .BUSY_OUT(BUSY_OUT)
);

// [testbench/wch_front_end_model.sv]
// Behavioural analogue front end giving ten sampled channels
`timescale 1ns/1ps
module wch_front_end_model #(
  parameter int RATE_DIV = 2 // Cycles between new samples
) (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic [15:0] step_in, // Phase step per sample
  output logic [119:0] samples_out // Ten channels, channel 0 low
);
  // Peak of each channel; channel 0 adds a 20 percent third harmonic
  localparam int AMP [10] = '{1500, 200, 450, 900, 600, 120, 350, 750, 1300, 80};
  logic [15:0] phase_reg;
  int div_cnt;
  ////////////////////////////////////////////////////////////
  // Phase advances once per sample period
  always_ff @(posedge clk_in) begin
    if (rst_in || div_cnt == RATE_DIV - 1) begin
      div_cnt <= 0;
    end else begin
      div_cnt <= div_cnt + 1;
    end
    if (rst_in) begin
      phase_reg <= 16'h0000;
    end else if (div_cnt == RATE_DIV - 1) begin
      phase_reg <= phase_reg + step_in;
    end
  end
  // Each source has its own amplitude so selection shows
  always_comb begin
    real th;
    th = 6.283185307 * real'(phase_reg) / 65536.0;
    for (int n = 0; n < 10; n++) begin
      samples_out[12*n +: 12] = 12'($rtoi(AMP[n] * $sin(th) + ((n == 0) ? 300.0 * $cos(3.0 * th) : 0.0)));
    end
  end
endmodule // wch_front_end_model

// [testbench/wch_capture_tb_top.sv]
// Self-checking bench for display capture and harmonic analysis
`timescale 1ns/1ps
module wch_capture_tb_top;
  import wch_pkg::*;
  localparam int PERIOD = 8000;
  logic clk, rst, valid, update, busy;
  wch_chan_type chan;
  logic [119:0] samples;
  logic [15:0] step;
  logic [6:0] rd_addr, wr_ptr;
  logic [5:0] order, hmax;
  logic [11:0] rd_data;
  logic [1:0] gain;
  logic [9:0] level;
  logic [12:0] thd;
  int errors, n_checks;
  ////////////////////////////////////////////////////////////
  // Design with shortened rate counts and the front end model
  wch_capture_top #(.DISP_DIV(4), .ANL_DIV(2), .ANL_PERIOD(PERIOD)) dut (
    .CLK_IN(clk),
    .SYS_RST_IN(rst),
    .CHAN_SEL_IN(chan),
    .SAMPLES_IN(samples),
    .FUND_STEP_IN(step),
    .DISP_RD_ADDR_IN(rd_addr),
    .HARM_RD_ORDER_IN(order),
    .DISP_RD_DATA_OUT(rd_data),
    .DISP_WR_PTR_OUT(wr_ptr),
    .DISP_GAIN_OUT(gain),
    .HARM_LEVEL_OUT(level),
    .THD_OUT(thd),
    .HARM_MAX_OUT(hmax),
    .RESULT_VALID_OUT(valid),
    .RESULT_UPDATE_OUT(update),
    .BUSY_OUT(busy)
  );
  wch_front_end_model #(.RATE_DIV(2)) u_front (.clk_in(clk), .rst_in(rst), .step_in(step), .samples_out(samples));
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  // Comparisons and closing report
  task automatic chk_val(string what, int exp, logic [15:0] got);
    n_checks++;
    if (got !== 16'(exp)) begin
      errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic chk_rng(string what, int lo, int hi, logic [15:0] got);
    n_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      errors++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Wait for the next result swap, bounded
  task automatic wait_update(output int waited);
    waited = 0;
    do begin
      @(negedge clk);
      waited++;
    end while (update !== 1'b1 && waited < 20000);
    if (update !== 1'b1) begin
      errors++;
      $display("Error result swap expected 1 seen %0b", update);
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Outputs cleared while reset is held
  task automatic t_reset();
    chk_val("busy", 0, 16'(busy));
    chk_val("valid", 0, 16'(valid));
    chk_val("swap", 0, 16'(update));
    chk_val("top order", 0, 16'(hmax));
    chk_val("distortion", 0, 16'(thd));
    chk_val("gain", 0, 16'(gain));
    chk_val("write index", 0, 16'(wr_ptr));
  endtask
  // Gain and buffer peak for several sources, then reads past the end
  task automatic t_display();
    wch_chan_type chs [10] = '{CH_V2, CH_V3, CH_U12, CH_U23, CH_U31, CH_I1, CH_I2, CH_I3, CH_IN, CH_V1};
    int gains [10] = '{3, 2, 1, 1, 3, 2, 1, 0, 3, 0};
    int amps [10] = '{200, 450, 900, 600, 120, 350, 750, 1300, 80, 1500};
    int peak, s;
    for (int k = 0; k < 10; k++) begin
      chan = chs[k];
      repeat (1300) @(negedge clk);
      chk_val("display gain", gains[k], 16'(gain));
      peak = 0;
      for (int a = 0; a < 100; a++) begin
        rd_addr = 7'(a);
        @(negedge clk);
        s = int'($signed(rd_data));
        peak = (s > peak) ? s : ((-s > peak) ? -s : peak);
      end
      chk_rng("display peak", amps[k] * 3 / 4, amps[k] * 6 / 5, 16'(peak));
    end
    for (int a = 100; a < 128; a += 27) begin
      rd_addr = 7'(a);
      @(negedge clk);
      chk_val("display read past end", 0, 16'(rd_data));
    end
    rd_addr = 7'h00;
  endtask
  // Analysis of channel V1 at a new fundamental step
  task automatic t_analysis(logic [15:0] new_step, int top, int lo3, int hi3, int tlo, int thi);
    int waited;
    wait_update(waited);
    repeat (2) @(negedge clk);
    step = new_step;
    chan = CH_V1;
    wait_update(waited);
    wait_update(waited);
    chk_val("analysis interval", PERIOD, 16'(waited));
    repeat (2) @(negedge clk);
    chk_val("top order", top, 16'(hmax));
    chk_val("valid", 1, 16'(valid));
    chk_val("busy after swap", 0, 16'(busy));
    chk_rng("distortion", tlo, thi, 16'(thd));
    order = 6'h01;
    @(negedge clk);
    chk_val("fundamental level", 1000, 16'(level));
    order = 6'h03;
    @(negedge clk);
    chk_rng("third level", lo3, hi3, 16'(level));
    order = 6'(top + 1);
    @(negedge clk);
    chk_val("level above top", 0, 16'(level));
    order = 6'h00;
    @(negedge clk);
    chk_val("level order zero", 0, 16'(level));
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    chan = CH_V1;
    step = 16'h0fc0;
    rd_addr = 7'h00;
    order = 6'h00;
    errors = 0;
    n_checks = 0;
    repeat (6) @(negedge clk);
    t_reset();
    rst = 1'b0;
    t_display();
    t_analysis(16'h0fc0, 4, 120, 300, 120, 320);
    t_analysis(16'h1a40, 2, 0, 0, 0, 30);
    end_of_test();
  end
endmodule // wch_capture_tb_top
